// ### hdl/grs_pkg.sv
// constants, register map and carrier types for the gear and speed-select front end
package grs_pkg;

   // register port widths
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;

   // register offsets (word index on the register port)
   localparam logic [3:0] OFS_GEAR_NUM = 4'h0;
   localparam logic [3:0] OFS_GEAR_DEN = 4'h1;
   localparam logic [3:0] OFS_SPD1 = 4'h2;
   localparam logic [3:0] OFS_SPD2 = 4'h3;
   localparam logic [3:0] OFS_SPD3 = 4'h4;
   localparam logic [3:0] OFS_RAMP_UP = 4'h5;
   localparam logic [3:0] OFS_RAMP_DOWN = 4'h6;
   localparam logic [3:0] OFS_MEMSW2 = 4'h7;
   localparam logic [3:0] OFS_OPTIONS = 4'h8;
   localparam logic [3:0] OFS_CONTROL = 4'h9;
   localparam logic [3:0] OFS_MONITOR = 4'ha;
   localparam logic [3:0] OFS_SPEED_REF = 4'hb;

   // values after reset
   localparam logic [15:0] RST_GEAR_NUM = 16'h0001;
   localparam logic [15:0] RST_GEAR_DEN = 16'h0001;
   localparam logic [15:0] RST_SPD1 = 16'h0064;
   localparam logic [15:0] RST_SPD2 = 16'h00c8;
   localparam logic [15:0] RST_SPD3 = 16'h012c;
   localparam logic [15:0] RST_RAMP = 16'h0000;
   localparam logic [15:0] RST_MEMSW2 = 16'h0000;
   localparam logic [15:0] RST_OPTIONS = 16'h0000;

   // field positions
   localparam int MEMSW2_SPEED_SEL_BIT = 2;
   localparam int OPT_PULSE_IN_STOP_BIT = 0;
   localparam int CTRL_REINIT_BIT = 0;
   localparam int MON_DIR_SEL_BIT = 0;
   localparam int MON_PULSE_BIT = 1;
   localparam int MON_PULSE_DIR_BIT = 2;
   localparam int MON_INHIBIT_BIT = 3;
   localparam int MON_IN_POS_BIT = 4;
   localparam int MON_WAIT_BIT = 5;
   localparam int MON_SPEED_MODE_BIT = 6;
   localparam int MON_SEL_LO_BIT = 7;
   localparam int MON_SEL_HI_BIT = 8;
   localparam int MON_POS_VAR_BIT = 9;

   // top speed that the ramp times refer to, in r/min
   localparam logic [15:0] MAX_SPEED_RPM = 16'h1194;

   // ramp time unit and the clock; cycles per ramp unit derived from them
   localparam int CLK_PERIOD_NS = 10;
   localparam int RAMP_UNIT_NS = 1000000;
   localparam int CYC_PER_MS_DEF = RAMP_UNIT_NS / CLK_PERIOD_NS;

   // cycles after reset release at which the variant strap is caught
   localparam logic [1:0] STRAP_CAPTURE_CYC = 2'h2;

   // pins from the outside world, all asynchronous to clock
   typedef struct packed {
      logic strap_position; // high: position-control variant
      logic inhibit;        // reference pulse inhibit
      logic pulse;          // reference pulse
      logic pulse_dir;      // reference pulse direction, high = reverse
      logic dir_sel;        // direction_select_input
      logic sel_a;          // select_input_a
      logic sel_b;          // select_input_b
   } grs_pins_t;

   // run state of the reference front end
   typedef enum {
      RUN_NORMAL,     // speed select off
      RUN_STOP,       // speed select, both selects off, stopped
      RUN_PULSE_WAIT, // leaving a preset, pulses held off until in position
      RUN_PULSE,      // speed select, both selects off, pulses taken
      RUN_PRESET      // speed select, a preset speed running
   } grs_run_t;

endpackage

// ### hdl/grs_ramp.sv
// soft start: rate-limits the commanded speed into the internal speed reference
`timescale 1ns/1ps
module grs_ramp
   import grs_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_PER_MS_DEF,
   parameter int W = 16
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic ramp_on,
   input wire logic signed [W-1:0] target,
   input wire logic [15:0] up_time,
   input wire logic [15:0] down_time,
   output logic signed [W-1:0] speed_ref_q
);
   logic [33:0] frac_q; // accumulated r/min fraction, scaled by limit
   logic [33:0] frac_d;
   logic signed [W-1:0] ref_d;

   // moving away from zero accelerates, moving toward zero decelerates
   wire rising = target > speed_ref_q;
   wire accel = (rising && speed_ref_q >= 0) || (!rising && speed_ref_q <= 0);
   wire [15:0] t_sel = accel ? up_time : down_time;
   // full-scale travel takes t_sel ms: one r/min step per limit/MAX cycles
   wire [33:0] limit = 34'(t_sel) * 34'(CYC_PER_MS);
   wire [33:0] frac_sum = frac_q + 34'(MAX_SPEED_RPM);
   wire direct = !ramp_on || (t_sel == 16'h0000) || (target == speed_ref_q);
   wire step = frac_sum >= limit;

   // next reference and fraction
   always_comb begin
      ref_d = speed_ref_q;
      frac_d = frac_sum;
      if (direct) begin
         ref_d = target;                                  // see R16
         frac_d = '0;
      end else if (step) begin
         frac_d = frac_sum - limit;                       // see R13 R14
         ref_d = rising ? speed_ref_q + W'(1) : speed_ref_q - W'(1); // see R15
      end
   end

   // ramp state
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         speed_ref_q <= '0;
         frac_q <= '0;
      end else if (clk_en) begin
         speed_ref_q <= ref_d;
         frac_q <= frac_d;
      end
   end
endmodule

// ### hdl/grs_sync.sv
// two-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module grs_sync #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q; // first stage, read only by the second

   // both stages freeze with the clock enable
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         meta_q <= '0;
         q <= '0;
      end else if (clk_en) begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// ### hdl/grs_top.sv
// electronic gear, contact-input speed selection and soft start front end
//
// Overview of operation
// R01: scale reference pulses by numerator over denominator
// R02: host keeps terms within 1..65535, default 1
// R03: host keeps gear ratio within 0.01..100
// R04: numerator four times lines, denominator reference units
// R05: gear acts only in position variant
// R06: switch off: P/PI select, current limits
// R07: bit 2 of switch word enables speed select
// R08: none stops or pulses; b preset1; both preset2
// R09: select a only runs third preset
// R10: direction input off forward, on reverse
// R11: three presets, defaults 100, 200, 300 r/min
// R12: speed select disables pulse inhibit
// R13: ramp up time zero to 4500 r/min
// R14: ramp down time full speed to stop
// R15: internal reference is rate limited command
// R16: ramp time zero passes command directly
// R17: position variant ramps only in speed select
// R18: switch changes meaning of monitor bits 7, 8
// R19: select input change seen within 6 ms
// R20: after preset, pulses ignored until positioning complete
// R21: gear and switch apply after reinitialisation
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module grs_top
   import grs_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata_q,
   input wire grs_pins_t pins,
   input wire logic in_position,
   input wire logic signed [15:0] ext_speed_ref,
   output logic enc_step_q,
   output logic enc_dir_q,
   output logic signed [15:0] speed_ref_q,
   output logic p_control_q,
   output logic fwd_limit_q,
   output logic rev_limit_q,
   output logic positioning_complete_q
);
   // software registers
   logic [15:0] gear_numerator_q;
   logic [15:0] gear_denominator_q;
   logic [15:0] preset_speed_first_q;
   logic [15:0] preset_speed_second_q;
   logic [15:0] preset_speed_third_q;
   logic [15:0] ramp_up_time_q;
   logic [15:0] ramp_down_time_q;
   logic [15:0] memory_switch_word_two_q;
   logic [15:0] options_q;

   // settings in force since the last reinitialisation
   logic [15:0] act_num_q;
   logic [15:0] act_den_q;
   logic act_speed_mode_q;

   // variant strap capture
   logic [1:0] strap_cnt_q;
   logic position_var_q;

   // synchronised pins and pulse edge
   logic [$bits(grs_pins_t)-1:0] pins_raw;
   grs_pins_t pins_s;
   logic pulse_prev_q;

   // run state and gear residue
   grs_run_t run_q;
   grs_run_t run_d;
   logic signed [33:0] acc_q;
   logic signed [33:0] acc_d;
   logic step_d;
   logic dir_d;

   // register port decode
   wire wr_num = reg_wr && (reg_addr == OFS_GEAR_NUM);
   wire wr_den = reg_wr && (reg_addr == OFS_GEAR_DEN);
   wire wr_sp1 = reg_wr && (reg_addr == OFS_SPD1);
   wire wr_sp2 = reg_wr && (reg_addr == OFS_SPD2);
   wire wr_sp3 = reg_wr && (reg_addr == OFS_SPD3);
   wire wr_up = reg_wr && (reg_addr == OFS_RAMP_UP);
   wire wr_down = reg_wr && (reg_addr == OFS_RAMP_DOWN);
   wire wr_memsw = reg_wr && (reg_addr == OFS_MEMSW2);
   wire wr_opt = reg_wr && (reg_addr == OFS_OPTIONS);
   wire reinit = reg_wr && (reg_addr == OFS_CONTROL) && reg_wdata[CTRL_REINIT_BIT];

   // pins cross into the clock domain
   assign pins_raw = pins;
   grs_sync #(
      .W($bits(grs_pins_t))
   ) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .d(pins_raw),
      .q(pins_s)
   );

   // selection decode
   wire speed_mode = act_speed_mode_q;
   wire sel_none = !pins_s.sel_a && !pins_s.sel_b; // see R19
   wire pulse_in_stop = position_var_q && options_q[OPT_PULSE_IN_STOP_BIT];
   wire pulse_edge = pins_s.pulse && !pulse_prev_q;
   wire pulse_take = position_var_q && pulse_edge &&
      ((run_q == RUN_NORMAL && !pins_s.inhibit) ||   // see R12
       (run_q == RUN_PULSE));                        // see R20

   // preset chosen by the two selects
   wire [15:0] preset_raw = !pins_s.sel_a ? preset_speed_first_q :       // see R08
      (pins_s.sel_b ? preset_speed_second_q : preset_speed_third_q);     // see R09
   wire [15:0] preset_mag = (preset_raw > MAX_SPEED_RPM) ? MAX_SPEED_RPM : preset_raw; // see R11
   wire signed [15:0] preset_signed = pins_s.dir_sel ? -$signed(preset_mag)
      : $signed(preset_mag);                                             // see R10

   // command fed to the soft start
   wire signed [15:0] target = (run_q == RUN_PRESET) ? preset_signed :
      ((run_q == RUN_NORMAL && !position_var_q) ? ext_speed_ref : 16'sh0000);
   // position variant ramps only under speed select; speed variant always
   wire ramp_on = !position_var_q || (speed_mode && run_q != RUN_PULSE); // see R17

   // input monitor word; bits 7 and 8 follow the switch
   wire [1:0] sel_code = {pins_s.sel_a, pins_s.sel_b};
   wire [1:0] preset_idx = (run_q != RUN_PRESET) ? 2'h0 :
      (!pins_s.sel_a ? 2'h1 : (pins_s.sel_b ? 2'h2 : 2'h3));
   wire [1:0] mon_sel = speed_mode ? preset_idx : sel_code;              // see R18
   wire [15:0] monitor_word = 16'(
      (32'(pins_s.dir_sel) << MON_DIR_SEL_BIT) |
      (32'(pins_s.pulse) << MON_PULSE_BIT) |
      (32'(pins_s.pulse_dir) << MON_PULSE_DIR_BIT) |
      (32'(pins_s.inhibit) << MON_INHIBIT_BIT) |
      (32'(positioning_complete_q) << MON_IN_POS_BIT) |
      (32'(run_q == RUN_PULSE_WAIT) << MON_WAIT_BIT) |
      (32'(speed_mode) << MON_SPEED_MODE_BIT) |
      (32'(mon_sel[0]) << MON_SEL_LO_BIT) |
      (32'(mon_sel[1]) << MON_SEL_HI_BIT) |
      (32'(position_var_q) << MON_POS_VAR_BIT));

   // read multiplexer, unmapped addresses read zero
   wire [15:0] rd_mux =
      (reg_addr == OFS_GEAR_NUM) ? gear_numerator_q :
      (reg_addr == OFS_GEAR_DEN) ? gear_denominator_q :
      (reg_addr == OFS_SPD1) ? preset_speed_first_q :
      (reg_addr == OFS_SPD2) ? preset_speed_second_q :
      (reg_addr == OFS_SPD3) ? preset_speed_third_q :
      (reg_addr == OFS_RAMP_UP) ? ramp_up_time_q :
      (reg_addr == OFS_RAMP_DOWN) ? ramp_down_time_q :
      (reg_addr == OFS_MEMSW2) ? memory_switch_word_two_q :
      (reg_addr == OFS_OPTIONS) ? options_q :
      (reg_addr == OFS_MONITOR) ? monitor_word :
      (reg_addr == OFS_SPEED_REF) ? speed_ref_q : 16'h0000;

   // run state transitions
   always_comb begin
      run_d = run_q;
      unique case (run_q)
         RUN_NORMAL, RUN_STOP, RUN_PULSE, RUN_PRESET: begin
            if (!speed_mode) begin
               run_d = RUN_NORMAL;                             // see R06
            end else if (!sel_none) begin
               run_d = RUN_PRESET;                             // see R08
            end else if (!pulse_in_stop) begin
               run_d = RUN_STOP;                               // see R08
            end else if (run_q == RUN_PRESET) begin
               run_d = RUN_PULSE_WAIT;                         // see R20
            end else begin
               run_d = RUN_PULSE;
            end
         end
         RUN_PULSE_WAIT: begin
            if (!speed_mode) begin
               run_d = RUN_NORMAL;
            end else if (!sel_none) begin
               run_d = RUN_PRESET;
            end else if (!pulse_in_stop) begin
               run_d = RUN_STOP;
            end else if (in_position) begin
               run_d = RUN_PULSE;                              // see R20
            end
         end
      endcase
   end

   // electronic gear: numerator per pulse, one encoder count per denominator
   always_comb begin
      acc_d = acc_q;
      if (pulse_take) begin
         acc_d = pins_s.pulse_dir ? acc_q - 34'(act_num_q) : acc_q + 34'(act_num_q); // see R01
      end
      step_d = 1'b0;
      dir_d = enc_dir_q;
      if (acc_q >= $signed(34'(act_den_q))) begin
         acc_d = acc_d - 34'(act_den_q);                       // see R01
         step_d = 1'b1;
         dir_d = 1'b0;
      end else if (acc_q <= -$signed(34'(act_den_q))) begin
         acc_d = acc_d + 34'(act_den_q);
         step_d = 1'b1;
         dir_d = 1'b1;
      end
   end

   // software-written registers
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         gear_numerator_q <= RST_GEAR_NUM;
         gear_denominator_q <= RST_GEAR_DEN;
         preset_speed_first_q <= RST_SPD1;
         preset_speed_second_q <= RST_SPD2;
         preset_speed_third_q <= RST_SPD3;
         ramp_up_time_q <= RST_RAMP;
         ramp_down_time_q <= RST_RAMP;
         memory_switch_word_two_q <= RST_MEMSW2;
         options_q <= RST_OPTIONS;
      end else if (clk_en) begin
         if (wr_num) gear_numerator_q <= reg_wdata;
         if (wr_den) gear_denominator_q <= reg_wdata;
         if (wr_sp1) preset_speed_first_q <= reg_wdata;    // see R11
         if (wr_sp2) preset_speed_second_q <= reg_wdata;
         if (wr_sp3) preset_speed_third_q <= reg_wdata;
         if (wr_up) ramp_up_time_q <= reg_wdata;           // see R13
         if (wr_down) ramp_down_time_q <= reg_wdata;       // see R14
         if (wr_memsw) memory_switch_word_two_q <= reg_wdata;
         if (wr_opt) options_q <= reg_wdata;
      end
   end

   // settings in force load only on reinitialisation
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         act_num_q <= RST_GEAR_NUM;
         act_den_q <= RST_GEAR_DEN;
         act_speed_mode_q <= RST_MEMSW2[MEMSW2_SPEED_SEL_BIT];
      end else if (clk_en && reinit) begin
         act_num_q <= gear_numerator_q;                                     // see R21
         act_den_q <= gear_denominator_q;
         act_speed_mode_q <= memory_switch_word_two_q[MEMSW2_SPEED_SEL_BIT]; // see R07
      end
   end

   // catch the variant strap once it has passed the synchroniser
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         strap_cnt_q <= 2'h0;
         position_var_q <= 1'b0;
      end else if (clk_en && strap_cnt_q != 2'h3) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         if (strap_cnt_q == STRAP_CAPTURE_CYC) position_var_q <= pins_s.strap_position; // see R05
      end
   end

   // run state, gear residue and encoder count outputs
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         run_q <= RUN_NORMAL;
         acc_q <= '0;
         pulse_prev_q <= 1'b0;
         enc_step_q <= 1'b0;
         enc_dir_q <= 1'b0;
      end else if (clk_en) begin
         run_q <= run_d;
         acc_q <= acc_d;
         pulse_prev_q <= pins_s.pulse;
         enc_step_q <= step_d && position_var_q;   // see R05
         enc_dir_q <= dir_d;
      end
   end

   // contact outputs in standard mode and the read port
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         p_control_q <= 1'b0;
         fwd_limit_q <= 1'b0;
         rev_limit_q <= 1'b0;
         positioning_complete_q <= 1'b0;
         reg_rdata_q <= '0;
      end else if (clk_en) begin
         p_control_q <= (run_d == RUN_NORMAL) && pins_s.dir_sel;  // see R06
         fwd_limit_q <= (run_d == RUN_NORMAL) && pins_s.sel_a;    // see R06
         rev_limit_q <= (run_d == RUN_NORMAL) && pins_s.sel_b;    // see R06
         positioning_complete_q <= in_position;                  // see R20
         reg_rdata_q <= reg_rd ? rd_mux : 16'h0000;
      end
   end

   // soft start of the internal speed reference
   grs_ramp #(
      .CYC_PER_MS(CYC_PER_MS),
      .W(16)
   ) u_ramp (
      .clock(clock),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .ramp_on(ramp_on),
      .target(target),
      .up_time(ramp_up_time_q),
      .down_time(ramp_down_time_q),
      .speed_ref_q(speed_ref_q)      // see R15
   );
endmodule

// ### verification/grs_host_model.sv
// host controller model: drives reference pulses and contact inputs
`timescale 1ns/1ps
module grs_host_model
   import grs_pkg::*;
(
   input wire logic clock,
   input wire logic positioning_complete_q,
   output grs_pins_t pins
);
   grs_pins_t pins_q = '0; // levels presented at the drive
   assign pins = pins_q;
   // set strap, inhibit and the three contact inputs after an edge
   task automatic set_ctl(input logic strap, inh, dir, a, b);
      @(posedge clock);
      pins_q.strap_position <= strap;
      pins_q.inhibit <= inh;
      pins_q.dir_sel <= dir;
      pins_q.sel_a <= a;
      pins_q.sel_b <= b;
   endtask
   // send n pulses, each level held four cycles; may wait for in position
   task automatic send(input int n, input logic rev, input logic wt);
      int k;
      k = 0;
      while (wt && positioning_complete_q !== 1'b1 && k < 1000) begin
         @(posedge clock);
         k++;
      end
      @(posedge clock);
      pins_q.pulse_dir <= rev;
      repeat (n) begin
         repeat (4) @(posedge clock);
         pins_q.pulse <= 1'b1;
         repeat (4) @(posedge clock);
         pins_q.pulse <= 1'b0;
      end
   endtask
endmodule

// ### verification/grs_top_checker.sv
// port assertions for the gear and speed-select front end
`timescale 1ns/1ps
module grs_top_checker
   import grs_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata_q,
   input wire grs_pins_t pins,
   input wire logic in_position,
   input wire logic signed [15:0] ext_speed_ref,
   input wire logic enc_step_q,
   input wire logic enc_dir_q,
   input wire logic signed [15:0] speed_ref_q,
   input wire logic p_control_q,
   input wire logic fwd_limit_q,
   input wire logic rev_limit_q,
   input wire logic positioning_complete_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic sw_pend_q; // switch bit written, waiting for reinit
   logic mode_q; // speed select mode in force
   logic up_nz_q; // ramp up time non-zero
   logic dn_nz_q; // ramp down time non-zero
   wire wr_on = reg_wr && clk_en;
   wire wr_sw = wr_on && reg_addr == OFS_MEMSW2;
   wire wr_init = wr_on && reg_addr == OFS_CONTROL && reg_wdata[CTRL_REINIT_BIT];
   wire wr_up = wr_on && reg_addr == OFS_RAMP_UP;
   wire wr_dn = wr_on && reg_addr == OFS_RAMP_DOWN;
   wire ramp_q = up_nz_q && dn_nz_q;
   // shadow of the mode and ramp settings, so mode only moves on reinit
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sw_pend_q <= 1'b0;
         mode_q <= 1'b0;
         up_nz_q <= 1'b0;
         dn_nz_q <= 1'b0;
      end else begin
         if (wr_sw) sw_pend_q <= reg_wdata[MEMSW2_SPEED_SEL_BIT];
         if (wr_init) mode_q <= sw_pend_q;
         if (wr_up) up_nz_q <= reg_wdata != 16'h0000;
         if (wr_dn) dn_nz_q <= reg_wdata != 16'h0000;
      end
   end
   AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
      else $error("read data not zero outside read");
   AST_COMPLETE: assert property (in_position [*2] |-> positioning_complete_q)
      else $error("positioning complete not following servo");
   AST_PCTRL: assert property ((!mode_q && pins.dir_sel) [*5] |-> p_control_q)
      else $error("proportional select not following direction input");
   AST_FWD_OFF: assert property ((!mode_q && !pins.sel_a) [*5] |-> !fwd_limit_q)
      else $error("forward limit without select input");
   AST_SPEED_OFF: assert property (mode_q && $past(mode_q, 3) |->
      !p_control_q && !fwd_limit_q && !rev_limit_q)
      else $error("standard outputs active in speed select mode");
   AST_RAMP_RATE: assert property (mode_q && ramp_q |=>
      16'(speed_ref_q - $past(speed_ref_q) + 16'h0001) <= 16'h0002)
      else $error("speed reference jumped while ramping");
   AST_DIR_STEP: assert property ($changed(enc_dir_q) |-> enc_step_q)
      else $error("encoder direction moved without a step");
   AST_NO_STEP_VAR: assert property ((!pins.strap_position) [*8] |-> !enc_step_q)
      else $error("encoder step on speed variant");
   cover property (enc_step_q && enc_dir_q);
   cover property (mode_q && speed_ref_q == 16'sh012c);
   cover property (mode_q && ramp_q && speed_ref_q != 16'sh0000);
   cover property ($rose(positioning_complete_q));
endmodule

// ### verification/grs_top_test.sv
// self-checking bench for the gear and speed-select front end
`timescale 1ns/1ps
module grs_top_test;
   import grs_pkg::*;
   localparam int CPM = 100; // short ms keeps the run brief
   logic clock;
   logic sys_rst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic in_position = 1'b0;
   logic [DATA_W-1:0] reg_rdata_q;
   grs_pins_t pins;
   logic signed [15:0] speed_ref_q, ext_ref = '0;
   logic enc_step_q, enc_dir_q, p_control_q, fwd_limit_q, rev_limit_q;
   logic positioning_complete_q;
   int error_cnt = 0;
   int checks_done = 0;
   int steps = 0; // encoder steps seen
   logic last_dir = 1'b0; // direction of the latest step
   logic [15:0] dflt [8] = '{RST_GEAR_NUM, RST_GEAR_DEN, RST_SPD1, RST_SPD2,
      RST_SPD3, RST_RAMP, RST_RAMP, RST_MEMSW2};
   logic [15:0] pexp [3] = '{16'h0064, 16'hff38, 16'h012c}; // signed preset targets
   logic [1:0] sel [3] = '{2'b01, 2'b11, 2'b10}; // {a, b} per preset
   grs_top #(.CYC_PER_MS(CPM)) dut (.clock(clock), .sys_rst(sys_rst), .clk_en(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_q(reg_rdata_q), .pins(pins), .in_position(in_position),
      .ext_speed_ref(ext_ref), .enc_step_q(enc_step_q), .enc_dir_q(enc_dir_q),
      .speed_ref_q(speed_ref_q), .p_control_q(p_control_q), .fwd_limit_q(fwd_limit_q),
      .rev_limit_q(rev_limit_q), .positioning_complete_q(positioning_complete_q));
   grs_host_model host (.clock(clock), .positioning_complete_q(positioning_complete_q),
      .pins(pins));
   // free-running clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // count every encoder step and keep its direction
   always @(posedge clock) begin
      if (enc_step_q === 1'b1) begin
         steps <= steps + 1;
         last_dir <= enc_dir_q;
      end
   end
   // compare one value and report a mismatch
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // print counts and verdict, then stop
   task automatic summarize();
      $display("checks=%0d errors=%0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one-cycle register write
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   // one-cycle register read, data taken next cycle
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata_q;
   endtask
   // read and compare
   task automatic rchk(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] v;
      rd(a, v);
      check(v, e);
   endtask
   // bounded wait for a speed reference value
   task automatic wait_speed(input logic [15:0] e, input int lim);
      int k;
      k = 0;
      while (speed_ref_q !== e && k < lim) begin
         @(posedge clock);
         k++;
      end
      check(speed_ref_q, e);
      if (k >= lim) summarize();
   endtask
   // send pulses and compare the steps
   task automatic pulse_chk(input int n, input logic rev, input logic wt, input int e);
      int s0;
      s0 = steps;
      host.send(n, rev, wt);
      repeat (40) @(posedge clock);
      check(16'(steps - s0), 16'(e));
      if (e > 0) check(16'(last_dir), 16'(rev));
   endtask
   // reset with the variant strap held
   task automatic reset_dut(input logic strap);
      sys_rst <= 1'b1;
      in_position <= 1'b0;
      host.set_ctl(strap, 1'b0, 1'b0, 1'b0, 1'b0);
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clock);
   endtask
   // main sequence
   initial begin
      logic [15:0] v;
      reset_dut(1'b1);
      for (int i = 0; i < 8; i++) rchk(4'(i), dflt[i]);
      rchk(4'hc, 16'h0000);
      host.set_ctl(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      repeat (6) @(posedge clock);
      check({13'h0000, p_control_q, fwd_limit_q, rev_limit_q}, 16'h0006);
      rd(OFS_MONITOR, v);
      check(16'(v[8:7]), 16'h0002);
      host.set_ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      wr(OFS_GEAR_NUM, 16'h0003);
      wr(OFS_GEAR_DEN, 16'h0002);
      pulse_chk(2, 1'b0, 1'b0, 2);
      wr(OFS_CONTROL, 16'h0001);
      pulse_chk(4, 1'b0, 1'b0, 6);
      pulse_chk(2, 1'b1, 1'b0, 3);
      wr(OFS_OPTIONS, 16'h0001);
      wr(OFS_MEMSW2, 16'h0004);
      wr(OFS_CONTROL, 16'h0001);
      rd(OFS_MONITOR, v);
      check(16'(v[6]), 16'h0001);
      for (int i = 0; i < 3; i++) begin
         host.set_ctl(1'b1, 1'b0, i == 1, sel[i][1], sel[i][0]);
         wait_speed(pexp[i], 50);
         rd(OFS_MONITOR, v);
         check(16'(v[8:7]), 16'(i + 1));
      end
      host.set_ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      pulse_chk(2, 1'b0, 1'b0, 0);
      in_position <= 1'b1;
      pulse_chk(2, 1'b0, 1'b1, 3);
      wr(OFS_OPTIONS, 16'h0000);
      wr(OFS_RAMP_UP, 16'h005a);
      wr(OFS_RAMP_DOWN, 16'h002d);
      rchk(OFS_RAMP_UP, 16'h005a);
      host.set_ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      repeat (100) @(posedge clock);
      check(16'(speed_ref_q >= 40 && speed_ref_q <= 60), 16'h0001);
      wait_speed(16'h0064, 400);
      host.set_ctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      repeat (50) @(posedge clock);
      check(16'(speed_ref_q >= 40 && speed_ref_q <= 60), 16'h0001);
      wait_speed(16'h0000, 200);
      reset_dut(1'b0);
      wr(OFS_GEAR_NUM, 16'h0002);
      wr(OFS_CONTROL, 16'h0001);
      pulse_chk(2, 1'b0, 1'b0, 0);
      ext_ref <= 16'sh00c8;
      wait_speed(16'h00c8, 20);
      summarize();
   end
endmodule
bind grs_top grs_top_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.clock(clock),
   .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .pins(pins),
   .in_position(in_position), .ext_speed_ref(ext_speed_ref), .enc_step_q(enc_step_q),
   .enc_dir_q(enc_dir_q), .speed_ref_q(speed_ref_q), .p_control_q(p_control_q),
   .fwd_limit_q(fwd_limit_q), .rev_limit_q(rev_limit_q),
   .positioning_complete_q(positioning_complete_q));
